// File: core/dfel_core.sv
// Drive fault and event logger with APB register access
// Summary of operation
// - Event log holds 256 entries, each with date and time.
// - Event entry 0 is newest; higher numbers step back in time.
// - Dates read year.month.day in Hungarian, day/month/year in English.
// - Mains off and on events logged only when enabled; log_power resets to 0, so the power-on event is never logged.
// - Start and stop commands logged only when enabled.
// - Digital or virtual input events are logged.
// - Heatsink reaching 60 C logs an event; cooling to 55 C logs another.
// - Error log holds 256 entries with date, time and hours counter 1.
// - Starts refused until newest error is acknowledged.
// - An error stops the drive, flashes the lamp, shows error state.
// - Operating values are frozen at the moment of an error.
// - Error entries numbered from newest: 0, -1 and further back.
// - Power off then on acknowledges the pending error.
// - Rising then falling edge on the acknowledge input acknowledges.
// - Terminal Enter acknowledges only while viewing the newest error.
// - Low supply voltage blocks error log writes and start commands.
// - Digital inputs 1 to 8 set as error sources raise external errors.
// - Virtual inputs 1 to 6 raise virtual errors.
// - Terminal stop without terminal control enabled raises a trip error.
// - Reference voltage above or below its range raises separate errors.
// - Bad stored checksum flags an error and refuses the parameter load.
// - No-motor error when enabled, 4 to 400 Hz, current under 6 percent.
// - External and even virtual errors also clear by automatic acknowledge; of the virtual errors, only those of inputs 2, 4 and 6 do here.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "dfel_params.svh"
module dfel_core import dfel_pkg::*; #(
  parameter int unsigned LAMP_CYC = `DFEL_LAMP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside the clock domain
  input wire logic [7:0] digital_in,
  input wire logic start_pin,
  input wire logic stop_pin,
  input wire logic ack_pin,
  input wire logic mains_fail,
  input wire logic supply_low,
  input wire logic reference_high_fault,
  input wire logic reference_low_fault,
  // Same-clock measurement and time inputs
  input wire logic [5:0] virtual_in,
  input wire logic [7:0] heatsink_temp,
  input wire logic shaft_stopped,
  input wire logic [15:0] out_freq_hz,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] rated_current,
  input wire dfel_date_s rtc_date,
  input wire logic [31:0] rtc_time,
  input wire logic [31:0] op_hours1,
  input wire logic [7:0][31:0] op_values,
  // Drive outputs
  output logic drive_run,
  output logic error_lamp,
  output logic error_state,
  output logic param_load_grant
);
  localparam int unsigned NSRC = 20;
  dfel_ctrl_s ctrl;
  logic [31:0] incfg;
  logic [7:0] ev_sel, er_sel, ev_wp, er_wp;
  logic [8:0] ev_cnt, er_cnt;
  logic [31:0] sum_stored, sum_calc;
  logic [3:0] cmd;
  logic [14:0] sync1, sync2, prev;
  logic por_done, hot, fault, fault_auto;
  dfel_ack_e ack_state;
  logic [NSRC-1:0] ev_pend, er_pend, ev_set, er_set, ev_clr, er_clr;
  logic [5:0] vi_prev;
  logic [31:0] lamp_cnt;
  dfel_entry_s ev_mem [`DFEL_LOG_DEPTH];
  dfel_err_entry_s er_mem [`DFEL_LOG_DEPTH];
  logic [7:0][31:0] snap;
  logic [4:0] ev_idx, er_idx;
  logic ev_any, er_any, ack, start_req, stop_req, wr, rd;
  logic [14:0] rise, fall;
  logic [22:0] cur_scaled, rated_scaled;
  dfel_entry_s ev_rd;
  dfel_err_entry_s er_rd;

  // Two-flop synchronisers for all pin inputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= {reference_low_fault, reference_high_fault, supply_low, mains_fail, ack_pin,
                stop_pin, start_pin, digital_in};
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  assign rise = sync2 & ~prev;
  assign fall = ~sync2 & prev;
  assign wr = psel & penable & pwrite & ~pready;
  assign rd = psel & penable & ~pwrite & ~pready;

  // Start and stop requests from pins and terminal
  assign start_req = rise[8] | cmd[`DFEL_CMD_START];
  assign stop_req = rise[9] | cmd[`DFEL_CMD_STOP];

  // Event sources
  always_comb begin
    ev_set = '0;
    ev_set[0] = ctrl.log_power & rise[11];
    ev_set[1] = ctrl.log_power & ~por_done;
    ev_set[2] = ctrl.log_start_stop & start_req;
    ev_set[3] = ctrl.log_start_stop & stop_req;
    ev_set[4] = ~hot & (heatsink_temp >= `DFEL_HOT_C);
    ev_set[5] = hot & (heatsink_temp <= `DFEL_COOL_C);
    ev_set[13:6] = rise[7:0] & incfg[15:8];
    ev_set[19:14] = virtual_in & ~vi_prev & incfg[27:22];
  end

  // Error sources
  assign cur_scaled = 23'(motor_current) * `DFEL_PCT_FULL;
  assign rated_scaled = 23'(rated_current) * `DFEL_NOMOTOR_PCT;
  always_comb begin
    er_set = '0;
    er_set[7:0] = rise[7:0] & incfg[7:0];
    er_set[13:8] = virtual_in & ~vi_prev & incfg[21:16];
    er_set[14] = cmd[`DFEL_CMD_STOP] & ~ctrl.term_ctrl_en;
    er_set[15] = rise[13];
    er_set[16] = rise[14];
    er_set[17] = cmd[`DFEL_CMD_LOAD] & (sum_stored != sum_calc);
    er_set[18] = drive_run & shaft_stopped & ~fault;
    er_set[19] = ctrl.nomotor_en & drive_run & ~fault & (out_freq_hz >= `DFEL_FMIN_HZ)
                 & (out_freq_hz <= `DFEL_FMAX_HZ) & (cur_scaled < rated_scaled);
  end

  // Lowest pending source is logged first
  always_comb begin
    ev_idx = '0;
    er_idx = '0;
    ev_any = |ev_pend;
    er_any = |er_pend;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (ev_pend[i]) ev_idx = 5'(i);
      if (er_pend[i]) er_idx = 5'(i);
    end
    ev_clr = ev_any ? (NSRC'(1) << ev_idx) : '0;
    er_clr = er_any ? (NSRC'(1) << er_idx) : '0;
  end

  // Sticky pending bits, a new set wins over the clear
  for (genvar g = 0; g < NSRC; g++) begin : g_pend
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ev_pend[g] <= 1'b0;
        er_pend[g] <= 1'b0;
      end else begin
        ev_pend[g] <= ev_set[g] | (ev_pend[g] & ~ev_clr[g]);
        er_pend[g] <= er_set[g] | (er_pend[g] & ~er_clr[g]);
      end
    end
  end

  // Event log write, oldest overwritten when full
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ev_wp <= '0;
      ev_cnt <= '0;
    end else if (ev_any) begin
      ev_wp <= ev_wp + 8'h01;
      if (ev_cnt != 9'(`DFEL_LOG_DEPTH)) ev_cnt <= ev_cnt + 9'h001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (ev_any) ev_mem[ev_wp] <= '{`DFEL_EV_CODE_BASE + 8'(ev_idx), rtc_date, rtc_time};
  end

  // Error log write, blocked while the supply is low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      er_wp <= '0;
      er_cnt <= '0;
    end else if (er_any && !sync2[12]) begin
      er_wp <= er_wp + 8'h01;
      if (er_cnt != 9'(`DFEL_LOG_DEPTH)) er_cnt <= er_cnt + 9'h001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (er_any && !sync2[12])
      er_mem[er_wp] <= '{'{`DFEL_ER_CODE_BASE + 8'(er_idx), rtc_date, rtc_time}, op_hours1};
  end

  // Selected entries, 0 is the newest
  assign ev_rd = ev_mem[ev_wp - 8'h01 - ev_sel];
  assign er_rd = er_mem[er_wp - 8'h01 - er_sel];

  // Heatsink hysteresis, power-on marker, virtual input history
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hot <= 1'b0;
      por_done <= 1'b0;
      vi_prev <= '0;
    end else begin
      if (ev_set[4]) hot <= 1'b1;
      else if (ev_set[5]) hot <= 1'b0;
      por_done <= 1'b1;
      vi_prev <= virtual_in;
    end
  end

  // Acknowledge edge pair on the acknowledge input
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_state <= ACK_IDLE;
    end else begin
      case (ack_state)
        ACK_IDLE: if (rise[10]) ack_state <= ACK_HIGH;
        ACK_HIGH: if (fall[10]) ack_state <= ACK_IDLE;
        default: ack_state <= ACK_IDLE;
      endcase
    end
  end
  assign ack = (ack_state == ACK_HIGH && fall[10])
             | (cmd[`DFEL_CMD_ENTER] & ctrl.err_view & (er_sel == 8'h00))
             | (ctrl.auto_ack_en & fault_auto & ~|sync2[7:0] & ~|virtual_in);

  // Fault latch: reset (power cycle) clears it, a new error wins over ack
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fault <= 1'b0;
      fault_auto <= 1'b0;
    end else if (|er_set) begin
      fault <= 1'b1;
      fault_auto <= (fault ? fault_auto : 1'b1) & ~|(er_set & ~`DFEL_ER_AUTO_MASK);
    end else if (ack) begin
      fault <= 1'b0;
      fault_auto <= 1'b0;
    end
  end

  // Snapshot of operating values at the error
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) snap <= '0;
    else if (|er_set && !fault) snap <= op_values;
  end

  // Drive run control and error state display
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      drive_run <= 1'b0;
      error_state <= 1'b0;
    end else begin
      error_state <= fault | (|er_set);
      if (|er_set || stop_req) drive_run <= 1'b0;
      else if (start_req && !fault && !sync2[12]) drive_run <= 1'b1;
    end
  end

  // Error lamp flasher
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lamp_cnt <= '0;
      error_lamp <= 1'b0;
    end else if (!fault) begin
      lamp_cnt <= '0;
      error_lamp <= 1'b0;
    end else if (lamp_cnt >= LAMP_CYC - 1) begin
      lamp_cnt <= '0;
      error_lamp <= ~error_lamp;
    end else begin
      lamp_cnt <= lamp_cnt + 32'h1;
    end
  end

  // Parameter load grant only for a verified checksum
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) param_load_grant <= 1'b0;
    else param_load_grant <= cmd[`DFEL_CMD_LOAD] & (sum_stored == sum_calc);
  end

  // Register writes, command bits are one-cycle pulses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `DFEL_CTRL_RST;
      incfg <= `DFEL_INCFG_RST;
      ev_sel <= '0;
      er_sel <= '0;
      sum_stored <= '0;
      sum_calc <= '0;
      cmd <= '0;
    end else begin
      cmd <= '0;
      if (wr) begin
        if (paddr == `DFEL_OFS_CTRL) ctrl <= {25'h0, pwdata[6:0]};
        else if (paddr == `DFEL_OFS_CMD) cmd <= pwdata[3:0];
        else if (paddr == `DFEL_OFS_INCFG) incfg <= {4'h0, pwdata[27:0]};
        else if (paddr == `DFEL_OFS_EV_SEL) ev_sel <= pwdata[7:0];
        else if (paddr == `DFEL_OFS_ER_SEL) er_sel <= pwdata[7:0];
        else if (paddr == `DFEL_OFS_SUM_STORED) sum_stored <= pwdata;
        else if (paddr == `DFEL_OFS_SUM_CALC) sum_calc <= pwdata;
      end
    end
  end

  // Date in the selected language order
  function automatic logic [31:0] fmt_date(input dfel_date_s d, input logic eng);
    fmt_date = eng ? {d.day, d.month, d.year} : {d.year, d.month, d.day};
  endfunction : fmt_date

  // APB answer one cycle into the access phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (rd) begin
        if (paddr == `DFEL_OFS_CTRL) prdata <= ctrl;
        else if (paddr == `DFEL_OFS_STATUS)
          prdata <= {6'h0, er_cnt, ev_cnt, 4'h0, hot, sync2[12], fault_auto, fault};
        else if (paddr == `DFEL_OFS_CMD) prdata <= '0;
        else if (paddr == `DFEL_OFS_INCFG) prdata <= incfg;
        else if (paddr == `DFEL_OFS_EV_SEL) prdata <= {24'h0, ev_sel};
        else if (paddr == `DFEL_OFS_EV_CODE)
          prdata <= {24'h0, (9'(ev_sel) < ev_cnt) ? ev_rd.code : 8'h00};
        else if (paddr == `DFEL_OFS_EV_DATE) prdata <= fmt_date(ev_rd.date, ctrl.lang_english);
        else if (paddr == `DFEL_OFS_EV_TIME) prdata <= ev_rd.tod;
        else if (paddr == `DFEL_OFS_ER_SEL) prdata <= {24'h0, er_sel};
        else if (paddr == `DFEL_OFS_ER_CODE)
          prdata <= {24'h0, (9'(er_sel) < er_cnt) ? er_rd.ent.code : 8'h00};
        else if (paddr == `DFEL_OFS_ER_DATE)
          prdata <= fmt_date(er_rd.ent.date, ctrl.lang_english);
        else if (paddr == `DFEL_OFS_ER_TIME) prdata <= er_rd.ent.tod;
        else if (paddr == `DFEL_OFS_ER_HOURS) prdata <= er_rd.hours;
        else if (paddr == `DFEL_OFS_SUM_STORED) prdata <= sum_stored;
        else if (paddr == `DFEL_OFS_SUM_CALC) prdata <= sum_calc;
        else if (paddr[11:5] == `DFEL_OFS_SNAP >> 5 && paddr[1:0] == 2'b00)
          prdata <= snap[paddr[4:2]];
        else pslverr <= 1'b1;
      end else if (wr) begin
        if (paddr == `DFEL_OFS_STATUS || paddr[11:6] != 6'h00 || paddr[1:0] != 2'b00)
          pslverr <= 1'b1;
        else if (paddr == `DFEL_OFS_EV_CODE || paddr == `DFEL_OFS_EV_DATE) pslverr <= 1'b1;
        else if (paddr == `DFEL_OFS_EV_TIME || paddr[11:4] == 8'h02 && paddr[3:2] != 2'b00)
          pslverr <= 1'b1;
        else if (paddr == `DFEL_OFS_ER_HOURS) pslverr <= 1'b1;
      end
    end
  end

  // Checks
  property p_start_blocked;
    @(posedge sys_clk) disable iff (!resetn)
    (fault && !drive_run) |=> !drive_run;
  endproperty
  a_start_blocked: assert property (p_start_blocked) else $error("drive ran with fault");
  property p_trip_stops;
    @(posedge sys_clk) disable iff (!resetn)
    |er_set |=> !drive_run && error_state && fault;
  endproperty
  a_trip_stops: assert property (p_trip_stops) else $error("error did not trip");
  property p_lowv_start;
    @(posedge sys_clk) disable iff (!resetn)
    (sync2[12] && !drive_run) |=> !drive_run;
  endproperty
  a_lowv_start: assert property (p_lowv_start) else $error("start under low supply");
  property p_lowv_log;
    @(posedge sys_clk) disable iff (!resetn)
    sync2[12] |=> $stable(er_wp);
  endproperty
  a_lowv_log: assert property (p_lowv_log) else $error("error log written at low supply");
  property p_ev_ptr;
    @(posedge sys_clk) disable iff (!resetn)
    ev_any |=> ev_wp == $past(ev_wp) + 8'h01 && ev_cnt != 9'h000;
  endproperty
  a_ev_ptr: assert property (p_ev_ptr) else $error("event not logged");
  property p_hot;
    @(posedge sys_clk) disable iff (!resetn)
    (!hot && heatsink_temp >= `DFEL_HOT_C) |=> hot ##0 ev_pend[4] || ev_idx == 5'd4;
  endproperty
  a_hot: assert property (p_hot) else $error("hot event missed");
  property p_snap;
    @(posedge sys_clk) disable iff (!resetn)
    (|er_set && !fault) ##1 (fault && !(|er_set)) [*2] |-> $stable(snap);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot changed while tripped");
  property p_edge_ack;
    @(posedge sys_clk) disable iff (!resetn)
    (ack_state == ACK_HIGH && fall[10] && !(|er_set)) |=>
      !fault ##1 (!error_state || $past(|er_set));
  endproperty
  a_edge_ack: assert property (p_edge_ack) else $error("edge pair did not acknowledge");
  property p_chk;
    @(posedge sys_clk) disable iff (!resetn)
    (cmd[`DFEL_CMD_LOAD] && sum_stored != sum_calc) |=> !param_load_grant && fault;
  endproperty
  a_chk: assert property (p_chk) else $error("bad checksum loaded");
  c_trip: cover property (@(posedge sys_clk) disable iff (!resetn) drive_run ##1 fault);
  c_ack: cover property (@(posedge sys_clk) disable iff (!resetn) fault ##[1:20] !fault);
  c_wrap: cover property (@(posedge sys_clk) disable iff (!resetn) ev_cnt == 9'h100);
endmodule : dfel_core

// File: core/dfel_params.svh
// Offsets, field positions, codes and timing constants of the drive fault and event logger
`ifndef DFEL_PARAMS_SVH
`define DFEL_PARAMS_SVH
`define DFEL_CLK_MHZ 125
`define DFEL_LAMP_HALF_MS 250
`define DFEL_LAMP_CYC (`DFEL_LAMP_HALF_MS * `DFEL_CLK_MHZ * 1000)
`define DFEL_LOG_DEPTH 256
`define DFEL_OFS_CTRL 12'h000
`define DFEL_OFS_STATUS 12'h004
`define DFEL_OFS_CMD 12'h008
`define DFEL_OFS_INCFG 12'h00C
`define DFEL_OFS_EV_SEL 12'h010
`define DFEL_OFS_EV_CODE 12'h014
`define DFEL_OFS_EV_DATE 12'h018
`define DFEL_OFS_EV_TIME 12'h01C
`define DFEL_OFS_ER_SEL 12'h020
`define DFEL_OFS_ER_CODE 12'h024
`define DFEL_OFS_ER_DATE 12'h028
`define DFEL_OFS_ER_TIME 12'h02C
`define DFEL_OFS_ER_HOURS 12'h030
`define DFEL_OFS_SUM_STORED 12'h034
`define DFEL_OFS_SUM_CALC 12'h038
`define DFEL_OFS_SNAP 12'h040
`define DFEL_CTRL_RST 32'h0000_0000
`define DFEL_INCFG_RST 32'h0000_0000
`define DFEL_CMD_START 0
`define DFEL_CMD_STOP 1
`define DFEL_CMD_ENTER 2
`define DFEL_CMD_LOAD 3
`define DFEL_HOT_C 8'h3C
`define DFEL_COOL_C 8'h37
`define DFEL_FMIN_HZ 16'h0004
`define DFEL_FMAX_HZ 16'h0190
`define DFEL_NOMOTOR_PCT 23'h000006
`define DFEL_PCT_FULL 23'h000064
`define DFEL_EV_CODE_BASE 8'h01
`define DFEL_ER_CODE_BASE 8'h40
`define DFEL_ER_AUTO_MASK 20'h02AFF
`endif

// File: core/dfel_pkg.sv
// Types of the drive fault and event logger
package dfel_pkg;
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
  } dfel_date_s;
  typedef struct packed {
    logic [7:0] code;
    dfel_date_s date;
    logic [31:0] tod;
  } dfel_entry_s;
  typedef struct packed {
    dfel_entry_s ent;
    logic [31:0] hours;
  } dfel_err_entry_s;
  typedef struct packed {
    logic [24:0] rsvd;
    logic err_view;
    logic auto_ack_en;
    logic term_ctrl_en;
    logic nomotor_en;
    logic lang_english;
    logic log_start_stop;
    logic log_power;
  } dfel_ctrl_s;
  typedef enum logic [0:0] {ACK_IDLE, ACK_HIGH} dfel_ack_e;
endpackage : dfel_pkg

// File: test/dfel_pin_model.sv
// Model of the outside control pins: digital inputs, acknowledge and start buttons
`timescale 1ns/100ps
module dfel_pin_model (
  // Clock
  input wire logic sys_clk,
  // Pins toward the logger, low when released
  output logic [7:0] digital_in,
  output logic ack_pin,
  output logic start_pin
);
  // Released pins sit at their pull-down level
  initial begin
    digital_in = 8'h00;
    ack_pin = 1'b0;
    start_pin = 1'b0;
  end
  // Level change on the digital inputs
  task automatic set_in(input logic [7:0] v);
    @(posedge sys_clk);
    digital_in <= v;
  endtask : set_in
  // Rising then falling edge, each level held past the synchroniser
  task automatic ack_pair();
    @(posedge sys_clk);
    ack_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ack_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : ack_pair
  // Start button press of a few clocks
  task automatic press_start();
    @(posedge sys_clk);
    start_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    start_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : press_start
endmodule : dfel_pin_model

// File: test/tb_top.sv
// Self-checking bench for the drive fault and event logger
`timescale 1ns/100ps
module tb_top import dfel_pkg::*;;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] digital_in;
  logic ack_pin;
  logic start_pin;
  logic mains_fail = 1'b0;
  logic supply_low = 1'b0;
  logic reference_high_fault = 1'b0;
  logic reference_low_fault = 1'b0;
  logic stop_pin = 1'b0;
  logic shaft_stopped = 1'b0;
  logic [15:0] motor_current = 16'h0100;
  logic [5:0] virtual_in = 6'h00;
  logic [7:0] heatsink_temp = 8'h19;
  logic [7:0][31:0] op_values = 256'h0;
  dfel_date_s rtc_date = {16'h07E8, 8'h05, 8'h1C};
  logic [31:0] rtc_time = 32'h0012_3456;
  logic [31:0] op_hours1 = 32'h0000_2A17;
  logic drive_run;
  logic error_lamp;
  logic error_state;
  logic param_load_grant;
  logic [31:0] rq;
  logic re;
  logic lamp_was;
  int fail_count = 0;
  int compares = 0;

  // Design with a short lamp period
  dfel_core #(.LAMP_CYC(4)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_in(digital_in), .start_pin(start_pin), .stop_pin(stop_pin), .ack_pin(ack_pin),
    .mains_fail(mains_fail), .supply_low(supply_low),
    .reference_high_fault(reference_high_fault), .reference_low_fault(reference_low_fault),
    .virtual_in(virtual_in), .heatsink_temp(heatsink_temp), .shaft_stopped(shaft_stopped),
    .out_freq_hz(16'h0032), .motor_current(motor_current), .rated_current(16'h0100),
    .rtc_date(rtc_date), .rtc_time(rtc_time), .op_hours1(op_hours1), .op_values(op_values),
    .drive_run(drive_run), .error_lamp(error_lamp), .error_state(error_state),
    .param_load_grant(param_load_grant)
  );

  // Pin partner for the digital, acknowledge and start inputs
  dfel_pin_model pins (
    .sys_clk(sys_clk), .digital_in(digital_in), .ack_pin(ack_pin), .start_pin(start_pin)
  );

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Comparison and mismatch report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  // One APB transfer: setup, access, wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rq, exp);
  endtask : rd

  // Bounded wait for the fault state to reach a level
  task automatic wait_fault(input logic v);
    int n;
    n = 0;
    while (error_state !== v && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chkb(error_state, v);
  endtask : wait_fault

  // Power-up: reset held ten clocks
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset

  // Counts and final verdict
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Test sequence
  initial begin
    do_reset();
    rd(12'h000, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0000);
    apb(1'b0, 12'h03C, 32'h0000_0000);
    chkb(re, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_00FF);
    chkb(re, 1'b1);
    $display("test registers done");
    wr(12'h000, 32'h0000_0012);
    wr(12'h008, 32'h0000_0001);
    rd(12'h014, 32'h0000_0003);
    chkb(drive_run, 1'b1);
    wr(12'h008, 32'h0000_0002);
    rd(12'h014, 32'h0000_0004);
    wr(12'h010, 32'h0000_0001);
    rd(12'h014, 32'h0000_0003);
    wr(12'h010, 32'h0000_0000);
    heatsink_temp <= 8'h3C;
    rd(12'h014, 32'h0000_0005);
    heatsink_temp <= 8'h37;
    rd(12'h014, 32'h0000_0006);
    rd(12'h018, 32'h07E8_051C);
    rd(12'h01C, 32'h0012_3456);
    mains_fail <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(12'h004, 32'h0000_0400);
    mains_fail <= 1'b0;
    wr(12'h000, 32'h0000_0007);
    mains_fail <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(12'h014, 32'h0000_0001);
    mains_fail <= 1'b0;
    rd(12'h018, 32'h1C05_07E8);
    $display("test events done");
    wr(12'h00C, 32'h0002_0001);
    wr(12'h008, 32'h0000_0001);
    op_values[0] <= 32'h1234_5678;
    pins.set_in(8'h01);
    wait_fault(1'b1);
    chkb(drive_run, 1'b0);
    op_values[0] <= 32'hFFFF_0000;
    rd(12'h040, 32'h1234_5678);
    rd(12'h024, 32'h0000_0040);
    rd(12'h030, 32'h0000_2A17);
    lamp_was = error_lamp;
    repeat (4) @(posedge sys_clk);
    chkb(error_lamp, ~lamp_was);
    wr(12'h008, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chkb(drive_run, 1'b0);
    pins.set_in(8'h00);
    pins.ack_pair();
    wait_fault(1'b0);
    chkb(error_lamp, 1'b0);
    pins.press_start();
    chkb(drive_run, 1'b1);
    $display("test external error done");
    virtual_in <= 6'h02;
    wait_fault(1'b1);
    virtual_in <= 6'h00;
    rd(12'h024, 32'h0000_0049);
    wr(12'h020, 32'h0000_0001);
    rd(12'h024, 32'h0000_0040);
    wr(12'h000, 32'h0000_0047);
    wr(12'h008, 32'h0000_0004);
    repeat (3) @(posedge sys_clk);
    chkb(error_state, 1'b1);
    wr(12'h020, 32'h0000_0000);
    wr(12'h008, 32'h0000_0004);
    wait_fault(1'b0);
    wr(12'h000, 32'h0000_0027);
    virtual_in <= 6'h02;
    wait_fault(1'b1);
    virtual_in <= 6'h00;
    wait_fault(1'b0);
    $display("test virtual error done");
    wr(12'h000, 32'h0000_0007);
    wr(12'h008, 32'h0000_0002);
    wait_fault(1'b1);
    rd(12'h024, 32'h0000_004E);
    do_reset();
    chkb(error_state, 1'b0);
    $display("test terminal trip done");
    supply_low <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(12'h008, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chkb(drive_run, 1'b0);
    reference_high_fault <= 1'b1;
    wait_fault(1'b1);
    rd(12'h004, 32'h0000_0005);
    supply_low <= 1'b0;
    reference_high_fault <= 1'b0;
    pins.ack_pair();
    wait_fault(1'b0);
    reference_low_fault <= 1'b1;
    wait_fault(1'b1);
    rd(12'h024, 32'h0000_0050);
    reference_low_fault <= 1'b0;
    $display("test supply and reference done");
    do_reset();
    wr(12'h034, 32'h0000_5A5A);
    wr(12'h038, 32'h0000_5A5A);
    wr(12'h008, 32'h0000_0008);
    @(posedge sys_clk);
    chkb(param_load_grant, 1'b1);
    wr(12'h038, 32'h0000_5A5B);
    wr(12'h008, 32'h0000_0008);
    @(posedge sys_clk);
    chkb(param_load_grant, 1'b0);
    wait_fault(1'b1);
    rd(12'h024, 32'h0000_0051);
    $display("test checksum done");
    do_reset();
    wr(12'h000, 32'h0000_0002);
    wr(12'h008, 32'h0000_0001);
    stop_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(12'h014, 32'h0000_0004);
    stop_pin <= 1'b0;
    wr(12'h008, 32'h0000_0001);
    shaft_stopped <= 1'b1;
    wait_fault(1'b1);
    rd(12'h024, 32'h0000_0052);
    shaft_stopped <= 1'b0;
    pins.ack_pair();
    wait_fault(1'b0);
    wr(12'h000, 32'h0000_000A);
    wr(12'h008, 32'h0000_0001);
    motor_current <= 16'h000F;
    wait_fault(1'b1);
    rd(12'h024, 32'h0000_0053);
    $display("test rotation done");
    heatsink_temp <= 8'h3C;
    wr(12'h00C, 32'h0040_0000);
    repeat (256) begin
      @(posedge sys_clk);
      virtual_in <= 6'h01;
      @(posedge sys_clk);
      virtual_in <= 6'h00;
    end
    wr(12'h010, 32'h0000_00FF);
    rd(12'h014, 32'h0000_000F);
    rd(12'h004, 32'h0005_0009);
    $display("test overwrite done");
    print_verdict();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
